// ---- common/sbsp_pkg.sv ----
/*
  Constants for the system bus slave port: region decode, time-out,
  reset sequencer length. Assumes one 25 MHz clock domain.
*/
package sbsp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 25;
  // Access time-out in microseconds
  localparam int TIMEOUT_US = 8;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLOCK_MHZ;
  // Reset procedure length in microseconds
  localparam int RESET_US = 4;
  localparam int RESET_CYCLES = RESET_US * CLOCK_MHZ;
  // Acknowledge latency after the strobe is seen; not used by the port, which acknowledges two cycles after start
  localparam int ACK_DELAY_CYCLES = 1;

  // ----------------------------------------------------------------
  // Address regions, word address A20..A1 upper bits
  // ----------------------------------------------------------------
  localparam logic [3:0] ROM_REGION = 4'h8;
  localparam logic [3:0] IO_REGION = 4'hf;
  localparam logic [15:0] DATA_RESET = 16'h0000;

endpackage

// ---- logic/sbsp_port.sv ----
/*
  System bus slave port: strobe qualification, read data drive,
  transfer acknowledge, bus error time-out, ROM and I/O selects,
  reset and halt outputs, interrupt output.
  Assumes bus pins are asynchronous and pass a two-stage synchroniser;
  internal register side is on the same clock.
*/
//
// Behaviour
// - Drive data bus only on reads
// - Upper strobe selects data bits 15..8
// - Lower strobe selects data bits 7..0
// - Direction low writes, high reads
// - Transfers only while chip select asserted
// - Open-drain acknowledge when cycle may proceed
// - Reset output asserted during reset procedure
// - Halt output asserted during reset procedure
// - Bus error when strobe outlives time-out without acknowledge
// - ROM select in ROM region under strobe
// - I/O select in I/O region under strobe
// - Open-drain interrupt output
`timescale 1ns/100ps

module sbsp_port
  import sbsp_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYCLES,
  parameter int RESET_LEN = RESET_CYCLES
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // System bus pins
  input wire logic [20:1] i_addr,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe,
  input wire logic i_upper_byte_strobe_n,
  input wire logic i_lower_byte_strobe_n,
  input wire logic i_read_not_write,
  input wire logic i_device_select_n,
  output logic o_transfer_ack_n,
  output logic o_transfer_ack_oe,
  output logic o_reset_out_n,
  output logic o_reset_out_oe,
  output logic o_halt_out_n,
  output logic o_halt_out_oe,
  output logic o_bus_error_n,
  output logic o_bus_error_oe,
  output logic o_rom_select_n,
  output logic o_io_select_n,
  output logic o_irq_out_n,
  output logic o_irq_out_oe,
  // Internal resource side
  input wire logic i_irq,
  input wire logic [15:0] i_rd_data,
  output logic o_access,
  output logic o_write,
  output logic [1:0] o_lanes,
  output logic [20:1] o_addr,
  output logic [15:0] o_wr_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ACK, S_ERR} sbsp_state_e;

  typedef struct packed {
    logic [1:0] uds_s1;
    logic [1:0] lds_s1;
    logic [1:0] rw_s1;
    logic [1:0] cs_s1;
    logic [20:1] addr_m;
    logic [20:1] addr_s;
    logic [15:0] data_m;
    logic [15:0] data_s;
    sbsp_state_e st;
    logic [15:0] tmo;
    logic [15:0] rst_cnt;
    logic in_reset;
    logic [15:0] rdata;
    logic [15:0] wdata;
    logic [20:1] addr;
    logic drive;
    logic ack;
    logic berr;
    logic rom;
    logic io;
    logic access;
    logic write;
    logic [1:0] lanes;
  } sbsp_state_s;

  sbsp_state_s s_q;
  sbsp_state_s s_d;

  logic strobe;
  logic sel;
  logic rd;

  // Second synchroniser stage only
  assign strobe = !s_q.uds_s1[1] || !s_q.lds_s1[1];
  assign sel = !s_q.cs_s1[1];
  assign rd = s_q.rw_s1[1];

  always_comb
  begin
    s_d = s_q;
    s_d.uds_s1 = {s_q.uds_s1[0], i_upper_byte_strobe_n};
    s_d.lds_s1 = {s_q.lds_s1[0], i_lower_byte_strobe_n};
    s_d.rw_s1 = {s_q.rw_s1[0], i_read_not_write};
    s_d.cs_s1 = {s_q.cs_s1[0], i_device_select_n};
    // Address and data pins, two stages as well
    s_d.addr_m = i_addr;
    s_d.addr_s = s_q.addr_m;
    s_d.data_m = i_data;
    s_d.data_s = s_q.data_m;
    s_d.access = 1'b0;
    // Reset sequencer
    if (s_q.in_reset)
    begin
      if (s_q.rst_cnt >= 16'(RESET_LEN - 1))
        s_d.in_reset = 1'b0;
      else
        s_d.rst_cnt = s_q.rst_cnt + 16'h0001;
    end
    // Region selects follow strobes; address held by master
    s_d.rom = strobe && !s_q.in_reset &&
              s_q.addr_s[20:17] == ROM_REGION;
    s_d.io = strobe && !s_q.in_reset &&
             s_q.addr_s[20:17] == IO_REGION;
    // Time-out counter
    if (!strobe)
      s_d.tmo = 16'h0000;
    else if (s_q.tmo != 16'hffff)
      s_d.tmo = s_q.tmo + 16'h0001;
    case (s_q.st)
      S_IDLE:
      begin
        if (strobe && sel && !s_q.in_reset)
        begin
          s_d.st = S_WAIT;
          s_d.addr = s_q.addr_s;
          s_d.lanes = {!s_q.uds_s1[1], !s_q.lds_s1[1]};
          s_d.write = !rd;
          s_d.wdata = s_q.data_s;
          s_d.access = 1'b1;
        end
        else if (strobe && s_q.tmo >= 16'(TIMEOUT - 1))
        begin
          s_d.st = S_ERR;
          s_d.berr = 1'b1;
        end
      end
      S_WAIT:
      begin
        s_d.rdata = i_rd_data;
        s_d.drive = !s_q.write;
        s_d.ack = 1'b1;
        s_d.st = S_ACK;
      end
      S_ACK:
      begin
        if (!strobe)
        begin
          s_d.ack = 1'b0;
          s_d.drive = 1'b0;
          s_d.st = S_IDLE;
        end
      end
      S_ERR:
      begin
        if (!strobe)
        begin
          s_d.berr = 1'b0;
          s_d.st = S_IDLE;
        end
      end
      default:
        s_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
      s_q.uds_s1 <= 2'h3;
      s_q.lds_s1 <= 2'h3;
      s_q.rw_s1 <= 2'h3;
      s_q.cs_s1 <= 2'h3;
      s_q.st <= S_IDLE;
      s_q.in_reset <= 1'b1;
      s_q.rdata <= DATA_RESET;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign o_data = s_q.rdata;
  assign o_data_oe = s_q.drive;
  assign o_transfer_ack_n = 1'b0;
  assign o_transfer_ack_oe = s_q.ack;
  assign o_reset_out_n = 1'b0;
  assign o_reset_out_oe = s_q.in_reset;
  assign o_halt_out_n = 1'b0;
  assign o_halt_out_oe = s_q.in_reset;
  assign o_bus_error_n = 1'b0;
  assign o_bus_error_oe = s_q.berr;
  assign o_rom_select_n = !s_q.rom;
  assign o_io_select_n = !s_q.io;
  assign o_irq_out_n = 1'b0;
  assign o_irq_out_oe = i_irq;
  assign o_access = s_q.access;
  assign o_write = s_q.write;
  assign o_lanes = s_q.lanes;
  assign o_addr = s_q.addr;
  assign o_wr_data = s_q.wdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_start;
    s_q.st == S_IDLE && strobe && sel && !s_q.in_reset;
  endsequence

  sequence seq_ack;
    ##2 o_transfer_ack_oe;
  endsequence

  a_ack_after_start: assert property (
    @(posedge i_clock) disable iff (!i_nrst) seq_start |-> seq_ack)
    else $error("acknowledge not raised two cycles after start");

  a_ack_held_strobe: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_transfer_ack_oe && strobe |=> o_transfer_ack_oe)
    else $error("acknowledge dropped while strobe held");

  a_ack_release: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    s_q.st == S_ACK && !strobe |=> !o_transfer_ack_oe)
    else $error("acknowledge not released");

  a_data_hold: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_data_oe && strobe |=> o_data_oe)
    else $error("read data released while strobe held");

  a_berr_hold: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_bus_error_oe && strobe |=> o_bus_error_oe)
    else $error("bus error dropped while strobe held");

  a_drive_read_only: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_data_oe |-> !s_q.write)
    else $error("data driven on write");

  a_no_access_unsel: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_access |-> $past(sel) && $past(strobe))
    else $error("access without chip select");

  a_tmo_clear: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    !strobe |=> s_q.tmo == 16'h0000)
    else $error("time-out not cleared");

  a_berr_cause: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    $rose(o_bus_error_oe) |-> $past(strobe) &&
      $past(s_q.tmo) >= 16'(TIMEOUT - 1))
    else $error("bus error without time-out");

  a_rom_strobe: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    !o_rom_select_n |-> $past(strobe))
    else $error("ROM select without strobe");

  a_io_strobe: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    !o_io_select_n |-> $past(strobe))
    else $error("I/O select without strobe");

  a_reset_halt_pair: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_reset_out_oe |-> o_halt_out_oe && !o_access &&
      !o_transfer_ack_oe)
    else $error("access or halt mismatch during reset procedure");

  a_write_dir: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_access |-> o_write == !$past(rd))
    else $error("direction misread");

endmodule

// ---- tb/sbsp_host.sv ----
/*
  Bus master model for the system bus slave port.
  Assumes open-drain lines already resolved to pin levels.
*/
`timescale 1ns/100ps
module sbsp_host
(
  // Clock
  input wire logic i_clock,
  // Bus pins
  input wire logic i_ack_n,
  input wire logic i_berr_n,
  input wire logic i_rom_n,
  input wire logic i_io_n,
  input wire logic [15:0] i_bus,
  output logic [20:1] o_addr,
  output logic [15:0] o_data,
  output logic o_uds_n,
  output logic o_lds_n,
  output logic o_rw,
  output logic o_cs_n
);
  initial
  begin
    o_addr = 20'h00000;
    o_data = 16'h0000;
    o_uds_n = 1'b1;
    o_lds_n = 1'b1;
    o_rw = 1'b1;
    o_cs_n = 1'b1;
  end
  // One cycle: held until ack or bus error edge
  task automatic cycle(input logic [20:1] a, input logic rw,
    input logic [1:0] ln, input logic cs_n, input logic [15:0] wd,
    output logic [15:0] rd, output logic [3:0] st);
    int n;
    begin
      // Previous acknowledge or bus error must have gone away
      n = 0;
      do
      begin
        @(negedge i_clock);
        n++;
      end
      while ((i_ack_n !== 1'b1 || i_berr_n !== 1'b1) && n < 64);
      o_addr = a;
      o_rw = rw;
      o_cs_n = cs_n;
      o_data = rw ? ~wd : wd;
      o_uds_n = ~ln[1];
      o_lds_n = ~ln[0];
      n = 0;
      do
      begin
        @(negedge i_clock);
        n++;
      end
      while (i_ack_n !== 1'b0 && i_berr_n !== 1'b0 && n < 64);
      // Answer settled half a cycle after its launching edge
      rd = i_bus;
      st = {i_ack_n, i_berr_n, i_rom_n, i_io_n};
      o_uds_n = 1'b1;
      o_lds_n = 1'b1;
      o_cs_n = 1'b1;
      o_data = ~o_data;
    end
  endtask
endmodule

// ---- tb/test_system_bus_slave_port.sv ----
/*
  Testbench for the system bus slave port.
  Assumes the host model drives all bus pins.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  n_mismatch++; $display("CHECK FAILED t=%0t got %h exp %h", \
  $time, a, b); end end
module test_system_bus_slave_port;
  import sbsp_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, irq = 1'b0;
  logic [15:0] rdd = 16'h5a3c, dbus, odata, hdata, wdat, rd;
  logic [20:1] addr, oaddr;
  logic uds_n, lds_n, rw, cs_n, doe, ack_oe, rst_oe, hlt_oe, be_oe;
  logic rom_n, io_n, irq_oe, acc, wr;
  logic [1:0] lanes;
  logic [3:0] st;
  wire [4:0] od_n;
  int n_mismatch = 0, num_checks = 0, i, n_acc = 0;
  always #20 clk = ~clk;
  always @(negedge clk) if (acc === 1'b1) n_acc++;
  assign dbus = doe ? odata : hdata;
  sbsp_host host (.i_clock(clk), .i_ack_n(~ack_oe), .i_berr_n(~be_oe),
    .i_rom_n(rom_n), .i_io_n(io_n), .i_bus(dbus), .o_addr(addr),
    .o_data(hdata), .o_uds_n(uds_n), .o_lds_n(lds_n), .o_rw(rw),
    .o_cs_n(cs_n));
  sbsp_port #(.TIMEOUT(20), .RESET_LEN(5)) uut (.i_clock(clk),
    .i_nrst(nrst), .i_addr(addr), .i_data(dbus), .o_data(odata),
    .o_data_oe(doe), .i_upper_byte_strobe_n(uds_n),
    .i_lower_byte_strobe_n(lds_n), .i_read_not_write(rw),
    .i_device_select_n(cs_n), .o_transfer_ack_n(od_n[0]),
    .o_transfer_ack_oe(ack_oe), .o_reset_out_n(od_n[1]),
    .o_reset_out_oe(rst_oe), .o_halt_out_n(od_n[2]),
    .o_halt_out_oe(hlt_oe), .o_bus_error_n(od_n[3]),
    .o_bus_error_oe(be_oe), .o_rom_select_n(rom_n),
    .o_io_select_n(io_n), .o_irq_out_n(od_n[4]), .o_irq_out_oe(irq_oe),
    .i_irq(irq), .i_rd_data(rdd), .o_access(acc), .o_write(wr),
    .o_lanes(lanes), .o_addr(oaddr), .o_wr_data(wdat));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    `CHK({rst_oe, hlt_oe}, 2'b11)
    `CHK(od_n, 5'h00)
    for (i = 0; i < 20 && rst_oe !== 1'b0; i++) @(negedge clk);
    `CHK({rst_oe, hlt_oe, doe, ack_oe}, 4'b0000)
    $display("test reset done");
  endtask
  task automatic t_read();
    host.cycle(20'h12345, 1'b1, 2'b11, 1'b0, 16'h0, rd, st);
    `CHK(st, 4'b0111)
    `CHK(n_acc, 1)
    `CHK(rd, rdd)
    `CHK({wr, lanes, oaddr}, {3'b011, 20'h12345})
    repeat (4) @(negedge clk);
    `CHK({ack_oe, doe}, 2'b00)
    $display("test read done");
  endtask
  task automatic t_write();
    host.cycle(20'h0abcd, 1'b0, 2'b10, 1'b0, 16'hc3e1, rd, st);
    `CHK({st[3], doe}, 2'b00)
    `CHK({wr, lanes, wdat[15:8]}, {3'b110, 8'hc3})
    host.cycle(20'h0abce, 1'b0, 2'b01, 1'b0, 16'h7e19, rd, st);
    `CHK({lanes, wdat[7:0]}, {2'b01, 8'h19})
    `CHK(n_acc, 3)
    $display("test write done");
  endtask
  task automatic t_unsel();
    host.cycle(20'h81000, 1'b1, 2'b11, 1'b1, 16'h0, rd, st);
    `CHK(st, 4'b1001)
    host.cycle(20'hf0010, 1'b1, 2'b01, 1'b1, 16'h0, rd, st);
    `CHK(st, 4'b1010)
    repeat (4) @(negedge clk);
    `CHK({be_oe, rom_n, io_n}, 3'b011)
    `CHK(n_acc, 3)
    $display("test unselected done");
  endtask
  task automatic t_irq();
    @(negedge clk) irq = 1'b1;
    #1 `CHK(irq_oe, 1'b1)
    @(negedge clk) irq = 1'b0;
    #1 `CHK(irq_oe, 1'b0)
    $display("test irq done");
  endtask
  initial
  begin
    t_reset();
    t_read();
    t_write();
    t_unsel();
    t_irq();
    give_verdict();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule
